// ---- common/angle_params.svh ----
/*
   Constants for the angle sensor result word, its timing and its link.
   Assumes inclusion by the package and the design files; definitions only.
*/
`ifndef ANGLE_PARAMS_SVH
`define ANGLE_PARAMS_SVH

`define ANGLE_W 13
`define TEMP_W 7
`define ERR_W 2
`define WORD_W 24
`define THR_W 8
`define CNT_W 24
`define BITCNT_W 5

`define ERR_GENERAL 2'h0
`define ERR_INPUT 2'h1
`define ERR_OVERTEMP 2'h2
`define ERR_UNUSED 2'h3

`define CLK_MHZ 200
`define PWRUP_TIME_US 10000
`define PROBE_TIME_US 1000
`define SYNC_SETTLE 2

`define FIFO_DEPTH 8
`define FIFO_PTR_W 3

`endif

// ---- common/angle_pkg.sv ----
/*
   Types for the angle sensor result path: samples, result word, config.
   Assumes angle_params.svh is reachable by bare name.
*/
package angle_pkg;
`include "angle_params.svh"

   // one measurement from the sensor core
   typedef struct packed
   {
      logic [`ANGLE_W-1:0] angle;
      logic [`TEMP_W-1:0] temp;
      logic diagGeneral;
      logic diagInput;
   } sample_t;

   // word shifted out to the host, msb first
   typedef struct packed
   {
      logic angleValid;
      logic errActive;
      logic [`ERR_W-1:0] errCode;
      logic [`ANGLE_W-1:0] angle;
      logic [`TEMP_W-1:0] temp;
   } out_word_t;

   // nonvolatile thresholds word: shutdown high byte, warning low byte
   typedef struct packed
   {
      logic [`THR_W-1:0] shut;
      logic [`THR_W-1:0] warn;
   } thresh_cfg_t;

   typedef enum logic [1:0]
   {
      ST_PROBE = 2'h0,
      ST_WARM = 2'h1,
      ST_RUN = 2'h3,
      ST_CMD = 2'h2
   } phase_t;

endpackage : angle_pkg

// ---- rtl/angle_output_former.sv ----
/*
   Angle sensor result former: builds the result word (error code, angle,
   temperature, optional complement), supervises temperature, times power-up,
   decides command-mode entry from the pin levels, buffers words in a FIFO and
   hands them to the serial link domain, which shifts them out msb first.
   One word crosses per frame; a frame with nothing new repeats the last word.
   Assumes the sensor core delivers samples on ref_clk, the host drives
   select and clock, and select is steady around rising link clock edges.
*/
`timescale 1ns/1ps
`include "angle_params.svh"
module angle_output_former
   import angle_pkg::*;
#(
   parameter int PWRUP_TIME_US = `PWRUP_TIME_US,
   parameter int PROBE_TIME_US = `PROBE_TIME_US
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // samples from the sensor core
   input wire sample_t sampleIn,
   input wire logic sampleValid,
   output logic sampleReady,
   // configuration
   input wire thresh_cfg_t cfgThresh,
   input wire logic cfgComplement,
   // status
   output logic measValid,
   output logic commandMode,
   output logic tempWarning,
   output logic tempShutdown,
   // serial link
   input wire logic linkClk,
   input wire logic csB,
   output logic dataOut,
   output logic dataOutEn
);
   localparam logic [`CNT_W-1:0] PWRUP_CYC = `CNT_W'(PWRUP_TIME_US * `CLK_MHZ);
   localparam logic [`CNT_W-1:0] PROBE_CYC = `CNT_W'(PROBE_TIME_US * `CLK_MHZ);
   // pin synchronisers show reset levels for this many cycles
   localparam logic [`CNT_W-1:0] SETTLE_CYC = `CNT_W'(`SYNC_SETTLE);

   typedef struct packed
   {
      phase_t phase;
      logic [`CNT_W-1:0] pwrCnt;
      logic [`CNT_W-1:0] probeCnt;
      logic [1:0] csSync;
      logic [1:0] clkSync;
      logic [1:0] ackSync;
      logic reqTgl;
      out_word_t holdWord;
      logic warn;
      logic shut;
   } ref_state_t;

   typedef struct packed
   {
      logic [1:0] reqSync;
      logic ackTgl;
      out_word_t shadow;
      logic taken;
   } link_state_t;

   typedef struct packed
   {
      logic loaded;
      logic drive;
      logic [`WORD_W-1:0] shReg;
   } frame_state_t;

   ref_state_t ref_reg;
   ref_state_t ref_next;
   link_state_t link_reg;
   link_state_t link_next;
   frame_state_t frame_reg;
   frame_state_t frame_next;

   out_word_t formedWord;
   logic [`WORD_W-1:0] fifoOut;
   logic fifoOutValid;
   logic fifoOutReady;
   logic fifoInReady;
   logic running;
   logic sampleWarn;
   logic sampleShut;
   logic frameIdle;
   logic frameStart;

   // result word formation
   always_comb
   begin
      sampleWarn = ({1'b0, sampleIn.temp} >= {1'b0, cfgThresh.warn[`THR_W-1:1]});
      sampleShut = ({1'b0, sampleIn.temp} >= {1'b0, cfgThresh.shut[`THR_W-1:1]});
      formedWord.errActive = sampleIn.diagGeneral | sampleIn.diagInput | sampleWarn;
      if (sampleIn.diagGeneral)
      begin
         formedWord.errCode = `ERR_GENERAL;
      end
      else if (sampleIn.diagInput)
      begin
         formedWord.errCode = `ERR_INPUT;
      end
      else if (sampleWarn)
      begin
         formedWord.errCode = `ERR_OVERTEMP;
      end
      else
      begin
         formedWord.errCode = `ERR_UNUSED;
      end
      // warnings keep the angle usable, diagnosis failures do not
      formedWord.angleValid = ~(sampleIn.diagGeneral | sampleIn.diagInput);
      if (cfgComplement)
      begin
         formedWord.angle = ~sampleIn.angle;
         formedWord.temp = ~sampleIn.temp;
      end
      else
      begin
         formedWord.angle = sampleIn.angle;
         formedWord.temp = sampleIn.temp;
      end
   end

   assign running = (ref_reg.phase == ST_RUN);
   assign sampleReady = fifoInReady & running;
   // pop a new word only once the link has taken the held one
   assign fifoOutReady = running & (ref_reg.ackSync[1] == ref_reg.reqTgl);

   result_fifo
   #(
      .WIDTH(`WORD_W),
      .DEPTH(`FIFO_DEPTH),
      .PTR_W(`FIFO_PTR_W)
   )
   u_fifo
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .inData(formedWord),
      .inValid(sampleValid & running),
      .inReady(fifoInReady),
      .outData(fifoOut),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady)
   );

   // reference domain: mode entry, power-up timing, hand-off
   always_comb
   begin
      ref_next = ref_reg;
      ref_next.csSync = {ref_reg.csSync[0], csB};
      ref_next.clkSync = {ref_reg.clkSync[0], linkClk};
      ref_next.ackSync = {ref_reg.ackSync[0], link_reg.ackTgl};
      if (ref_reg.pwrCnt < PWRUP_CYC)
      begin
         ref_next.pwrCnt = ref_reg.pwrCnt + 1'b1;
      end
      case (ref_reg.phase)
         ST_PROBE:
         begin
            if (ref_reg.pwrCnt < SETTLE_CYC)
            begin
               // synchronisers still hold reset levels, not the pins
               ref_next.phase = ST_PROBE;
            end
            // select high and clock low, unbroken, selects command mode
            else if (ref_reg.csSync[1] && !ref_reg.clkSync[1])
            begin
               ref_next.probeCnt = ref_reg.probeCnt + 1'b1;
               if (ref_reg.probeCnt >= PROBE_CYC - 1'b1)
               begin
                  ref_next.phase = ST_CMD;
               end
            end
            else
            begin
               ref_next.phase = ST_WARM;
            end
         end
         ST_WARM:
         begin
            if (ref_reg.pwrCnt >= PWRUP_CYC - 1'b1)
            begin
               ref_next.phase = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (fifoOutValid && fifoOutReady)
            begin
               ref_next.holdWord = out_word_t'(fifoOut);
               ref_next.reqTgl = ~ref_reg.reqTgl;
            end
         end
         ST_CMD:
         begin
            ref_next.phase = ST_CMD;
         end
         default:
         begin
            ref_next.phase = ST_PROBE;
         end
      endcase
      if (sampleValid && sampleReady)
      begin
         ref_next.warn = sampleWarn;
         ref_next.shut = sampleShut;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ref_reg <= '0;
      end
      else
      begin
         ref_reg <= ref_next;
      end
   end

   // status outputs
   assign measValid = running;
   assign commandMode = (ref_reg.phase == ST_CMD);
   assign tempWarning = ref_reg.warn;
   assign tempShutdown = ref_reg.shut;

   // link domain: at most one new word per frame; taking more would let
   // the fifo run ahead of the host and lose words
   always_comb
   begin
      link_next = link_reg;
      link_next.reqSync = {link_reg.reqSync[0], ref_reg.reqTgl};
      if (frameStart)
      begin
         // new frame: allow one take
         link_next.taken = 1'b0;
      end
      else if ((link_reg.reqSync[1] != link_reg.ackTgl) && !link_reg.taken)
      begin
         link_next.shadow = ref_reg.holdWord;
         link_next.ackTgl = link_reg.reqSync[1];
         link_next.taken = 1'b1;
      end
   end

   always_ff @(posedge linkClk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         link_reg <= '0;
      end
      else
      begin
         link_reg <= link_next;
      end
   end

   // frame logic, cleared while select is high
   assign frameIdle = csB | ~rst_b;
   assign frameStart = ~frame_reg.loaded;

   // first edge of a frame loads the word, later edges shift it out
   always_comb
   begin
      frame_next = frame_reg;
      if (frameStart)
      begin
         frame_next.shReg = link_reg.shadow;
         frame_next.loaded = 1'b1;
         frame_next.drive = 1'b1;
      end
      else
      begin
         frame_next.shReg = {frame_reg.shReg[`WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge linkClk or posedge frameIdle)
   begin
      if (frameIdle)
      begin
         frame_reg <= '0;
      end
      else
      begin
         frame_reg <= frame_next;
      end
   end

   assign dataOut = frame_reg.shReg[`WORD_W-1];
   assign dataOutEn = frame_reg.drive;

endmodule : angle_output_former

// ---- rtl/result_fifo.sv ----
/*
   Flip-flop FIFO with valid/ready on both sides.
   Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "angle_params.svh"
module result_fifo
#(
   parameter int WIDTH = `WORD_W,
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int PTR_W = `FIFO_PTR_W
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // fill side
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // drain side
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wrPtr;
      logic [PTR_W-1:0] rdPtr;
      logic [PTR_W:0] count;
   } fifo_state_t;

   fifo_state_t state_reg;
   fifo_state_t state_next;
   logic doPush;
   logic doPop;

   assign inReady = (state_reg.count != (PTR_W+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign outValid = (state_reg.count != '0);
   assign outData = state_reg.mem[state_reg.rdPtr];
   assign doPush = inValid & inReady;
   assign doPop = outValid & outReady;

   always_comb
   begin
      state_next = state_reg;
      if (doPush)
      begin
         state_next.mem[state_reg.wrPtr] = inData;
         state_next.wrPtr = state_reg.wrPtr + 1'b1;
      end
      if (doPop)
      begin
         state_next.rdPtr = state_reg.rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
         state_next.count = state_reg.count + 1'b1;
      end
      else if (doPop && !doPush)
      begin
         state_next.count = state_reg.count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

endmodule : result_fifo

// ---- verification/angle_output_former_sva.sv ----
/*
   Port checker for angle_output_former: status, power-up timing and idle drive.
   Assumes a bind from the bench top and the angle package compiled first.
*/
`timescale 1ns/1ps
`include "angle_params.svh"
module angle_output_former_sva
   import angle_pkg::*;
#(
   parameter int PWRUP_TIME_US = 2
)
(
   // clock, reset, samples
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire sample_t sampleIn,
   input wire logic sampleValid,
   input wire logic sampleReady,
   input wire thresh_cfg_t cfgThresh,
   // status and link
   input wire logic measValid,
   input wire logic commandMode,
   input wire logic tempWarning,
   input wire logic tempShutdown,
   input wire logic csB,
   input wire logic dataOutEn
);
   localparam int PWR = PWRUP_TIME_US * `CLK_MHZ;
   int upCnt;
   logic take;
   assign take = sampleValid && sampleReady;
   // cycles since reset release, saturating
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         upCnt <= 0;
      else if (upCnt < PWR + 8)
         upCnt <= upCnt + 1;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_deselected;
      csB ##1 csB;
   endsequence
   property p_warn;
      take |=> tempWarning == ($past(sampleIn.temp) >= $past(cfgThresh.warn[7:1]));
   endproperty
   property p_shut;
      take |=> tempShutdown == ($past(sampleIn.temp) >= $past(cfgThresh.shut[7:1]));
   endproperty
   property p_hold;
      !take |=> $stable({tempWarning, tempShutdown});
   endproperty
   property p_early;
      $rose(measValid) |-> upCnt >= PWR - 8 && upCnt <= PWR + 8;
   endproperty
   property p_late;
      upCnt == PWR + 8 |-> measValid || commandMode;
   endproperty
   property p_idle;
      !measValid |-> !sampleReady;
   endproperty
   property p_cmd;
      commandMode || $past(commandMode) |-> commandMode && !measValid && !sampleReady;
   endproperty
   property p_off;
      s_deselected |-> !dataOutEn;
   endproperty
   a_warn: assert property (p_warn) else $error("warning flag");
   a_shut: assert property (p_shut) else $error("shutdown flag");
   a_hold: assert property (p_hold) else $error("flags moved");
   a_early: assert property (p_early) else $error("valid off time");
   a_late: assert property (p_late) else $error("valid missing");
   a_idle: assert property (p_idle) else $error("early accept");
   a_cmd: assert property (p_cmd) else $error("command mode");
   a_off: assert property (p_off) else $error("driving idle");
endmodule : angle_output_former_sva

// ---- verification/angle_output_former_tb_top.sv ----
/*
   Bench top: power-up, random sample bursts, framed drain, command entry.
   Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module angle_output_former_tb_top;
   import angle_pkg::*;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic sampleValid = 1'h0;
   logic cfgComplement = 1'h0;
   logic holdLow = 1'h0;
   logic go = 1'h0;
   sample_t sampleIn = '0;
   thresh_cfg_t cfgThresh = '0;
   logic sampleReady, measValid, commandMode, tempWarning, tempShutdown;
   logic linkClk, csB, dataOut, dataOutEn, rxDone;
   logic [23:0] rxWord;
   logic [23:0] last = '0;
   logic [23:0] q[$];
   int err_total = 0;
   int n_checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   angle_output_former #(.PWRUP_TIME_US(2), .PROBE_TIME_US(1)) dut
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .sampleIn(sampleIn),
      .sampleValid(sampleValid),
      .sampleReady(sampleReady),
      .cfgThresh(cfgThresh),
      .cfgComplement(cfgComplement),
      .measValid(measValid),
      .commandMode(commandMode),
      .tempWarning(tempWarning),
      .tempShutdown(tempShutdown),
      .linkClk(linkClk),
      .csB(csB),
      .dataOut(dataOut),
      .dataOutEn(dataOutEn)
   );
   spi_host_model host
   (
      .go(go),
      .holdLow(holdLow),
      .dataOut(dataOut),
      .dataOutEn(dataOutEn),
      .csB(csB),
      .linkClk(linkClk),
      .rxWord(rxWord),
      .rxDone(rxDone)
   );
   task chk(input logic ok, input string msg);
      n_checks++;
      if (!ok)
      begin
         err_total++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : chk
   function automatic logic [23:0] exp_word(sample_t s, thresh_cfg_t c, logic cp);
      logic [1:0] e;
      e = s.diagGeneral ? 2'h0 : s.diagInput ? 2'h1 : s.temp >= c.warn[7:1] ? 2'h2 : 2'h3;
      return {e[1], e != 2'h3, e, s.angle ^ {13{cp}}, s.temp ^ {7{cp}}};
   endfunction : exp_word
   task do_reset(input logic hl);
      holdLow <= hl;
      rst_b <= 1'h0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'h1;
   endtask : do_reset
   task fill(input logic cp);
      sample_t s;
      int acc;
      logic rdy;
      acc = 0;
      cfgComplement <= cp;
      cfgThresh <= 16'($urandom);
      @(posedge ref_clk);
      repeat (13)
      begin
         s = 22'($urandom);
         // first word sits exactly on the warning threshold
         if (acc == 0)
            s = {s.angle, cfgThresh.warn[7:1], 2'h0};
         sampleIn <= s;
         sampleValid <= 1'h1;
         // ready read between edges, where it has settled
         #1;
         rdy = sampleReady;
         @(posedge ref_clk);
         if (rdy === 1'h1)
         begin
            q.push_back(exp_word(s, cfgThresh, cfgComplement));
            acc++;
         end
      end
      sampleValid <= 1'h0;
      #1;
      chk(acc >= 8 && acc <= 9 && sampleReady === 1'h0, "fifo fill");
   endtask : fill
   task drain();
      for (int f = 0; f < 20 && q.size() > 0; f++)
      begin
         go <= 1'h1;
         @(posedge ref_clk);
         go <= 1'h0;
         wait (rxDone === 1'h1);
         @(posedge ref_clk);
         // an unchanged word is a resend
         if (rxWord !== last)
         begin
            chk(rxWord === q[0], "word");
            last = rxWord;
            void'(q.pop_front());
         end
      end
      chk(q.size() == 0, "drain");
   endtask : drain
   task final_report();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   initial
   begin
      void'($urandom(32'h5030F388));
      do_reset(1'h0);
      repeat (100) @(posedge ref_clk);
      #1;
      chk(measValid === 1'h0 && sampleReady === 1'h0, "early");
      repeat (320) @(posedge ref_clk);
      #1;
      chk(measValid === 1'h1 && commandMode === 1'h0, "powerup");
      $display("test powerup done");
      fill(1'h0);
      drain();
      fill(1'h1);
      drain();
      $display("test stream done");
      do_reset(1'h1);
      repeat (450) @(posedge ref_clk);
      #1;
      chk(commandMode === 1'h1 && measValid === 1'h0 && sampleReady === 1'h0, "cmd");
      $display("test command done");
      final_report();
   end
   initial
   begin
      #200us;
      chk(1'h0, "watchdog");
      final_report();
   end
endmodule : angle_output_former_tb_top
bind angle_output_former angle_output_former_sva #(.PWRUP_TIME_US(PWRUP_TIME_US)) chk_i
(
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .sampleIn(sampleIn),
   .sampleValid(sampleValid),
   .sampleReady(sampleReady),
   .cfgThresh(cfgThresh),
   .measValid(measValid),
   .commandMode(commandMode),
   .tempWarning(tempWarning),
   .tempShutdown(tempShutdown),
   .csB(csB),
   .dataOutEn(dataOutEn)
);

// ---- verification/spi_host_model.sv ----
/*
   Host side of the serial link: 24-clock frames, data taken on falling edges.
   Assumes go rises only while the link is idle.
*/
`timescale 1ns/1ps
module spi_host_model
(
   // control from bench
   input wire logic go,
   input wire logic holdLow,
   // link
   input wire logic dataOut,
   input wire logic dataOutEn,
   output logic csB,
   output logic linkClk,
   // received word
   output logic [23:0] rxWord,
   output logic rxDone
);
   logic clkLvl;
   // idle clock high; held low from reset asks for command mode
   assign linkClk = clkLvl && !holdLow;
   initial
   begin
      csB = 1'h1;
      clkLvl = 1'h1;
      rxWord = '0;
      rxDone = 1'h0;
   end
   always @(posedge go)
   begin
      rxDone = 1'h0;
      #41 csB = 1'h0;
      #32 clkLvl = 1'h0;
      repeat (24)
      begin
         #32 clkLvl = 1'h1;
         #32 clkLvl = 1'h0;
         rxWord = {rxWord[22:0], dataOut && dataOutEn};
      end
      #32 clkLvl = 1'h1;
      #32 csB = 1'h1;
      rxDone = 1'h1;
   end
endmodule : spi_host_model
